// ---- rtl/srp_mem.sv ----
`timescale 1ns/1ns
`default_nettype none

`include "srp_consts.svh"

module srp_mem
(
   // Fill side
   input wire logic wr_clk,
   input wire logic wr_en,
   input wire srp_pkg::srp_beat_t wr_addr,
   input wire srp_pkg::srp_data_t wr_data,
   // Burst side
   input wire logic rd_clk,
   input wire srp_pkg::srp_pair_t rd_addr,
   output srp_pkg::srp_data_t rd_lo,
   output srp_pkg::srp_data_t rd_hi
);

   // Two clocks on one array: controller keeps fills and reads apart
   srp_pkg::srp_data_t arr [0:(1<<(`SRP_ADDR_W+2))-1];

   always_ff @(posedge wr_clk)
   begin
      if (wr_en)
      begin
         arr[wr_addr] <= wr_data;
      end
   end

   // One pair per period feeds both launch edges
   always_ff @(posedge rd_clk)
   begin
      rd_lo <= arr[{rd_addr, 1'b0}];
      rd_hi <= arr[{rd_addr, 1'b1}];
   end

endmodule

`default_nettype wire

// ---- rtl/srp_read_port.sv ----
`timescale 1ns/1ns
`default_nettype none

`include "srp_consts.svh"

module srp_read_port
(
   // Core clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Array fill port, core clock
   input wire logic FILL_EN,
   input wire srp_pkg::srp_beat_t FILL_ADDR,
   input wire srp_pkg::srp_data_t FILL_DATA,
   // Input clock pair
   input wire logic INPUT_CLOCK_POS,
   input wire logic INPUT_CLOCK_NEG,
   // Read request
   input wire logic READ_PORT_SELECT_N,
   input wire srp_pkg::srp_addr_t ADDRESS,
   // Read data
   output logic [`SRP_DATA_W-1:0] READ_DATA_OUT,
   output logic READ_DATA_OE,
   output logic READ_DATA_VALID,
   // Echo clocks
   output logic ECHO_CLOCK,
   output logic ECHO_CLOCK_N
);

   // Core reset release
   logic core_rst_a_r;
   logic core_rst_n_r;

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         core_rst_a_r <= `SRP_BIT_RST;
         core_rst_n_r <= `SRP_BIT_RST;
      end
      else
      begin
         core_rst_a_r <= 1'b1;
         core_rst_n_r <= core_rst_a_r;
      end
   end

   // Link reset: asserts at once, releases through two link flops
   logic link_rst_a_r;
   logic link_rst_n_r;

   always_ff @(posedge INPUT_CLOCK_POS or negedge core_rst_n_r)
   begin
      if (!core_rst_n_r)
      begin
         link_rst_a_r <= `SRP_BIT_RST;
         link_rst_n_r <= `SRP_BIT_RST;
      end
      else
      begin
         link_rst_a_r <= 1'b1;
         link_rst_n_r <= link_rst_a_r;
      end
   end

   // Burst sequencing on the positive clock
   srp_pkg::srp_burst_e burst_r;
   srp_pkg::srp_burst_e burst_nxt;
   srp_pkg::srp_addr_t addr_r;
   srp_pkg::srp_addr_t addr_nxt;
   srp_pkg::srp_pair_t rd_pair;
   logic start;
   logic pair_ok;

   always_comb
   begin
      // Select seen during the second period is ignored: a burst needs two
      start = !READ_PORT_SELECT_N && (burst_r == srp_pkg::SRP_OPEN);
      pair_ok = start || (burst_r == srp_pkg::SRP_SECOND);
      burst_nxt = srp_pkg::SRP_OPEN;
      addr_nxt = addr_r;
      unique case (burst_r)
         srp_pkg::SRP_OPEN:
         begin
            if (start)
            begin
               burst_nxt = srp_pkg::SRP_SECOND;
               addr_nxt = ADDRESS;
            end
         end
         srp_pkg::SRP_SECOND:
         begin
            burst_nxt = srp_pkg::SRP_OPEN;
         end
      endcase
      // Lower pair from the pins, upper pair from the held address
      if (burst_r == srp_pkg::SRP_SECOND)
      begin
         rd_pair = {addr_r, 1'b1};
      end
      else
      begin
         rd_pair = {ADDRESS, 1'b0};
      end
   end

   always_ff @(posedge INPUT_CLOCK_POS or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
      begin
         burst_r <= srp_pkg::SRP_OPEN;
         addr_r <= `SRP_ADDR_RST;
      end
      else
      begin
         burst_r <= burst_nxt;
         addr_r <= addr_nxt;
      end
   end

   // Array
   srp_pkg::srp_data_t rd_lo;
   srp_pkg::srp_data_t rd_hi;

   srp_mem u_mem
   (
      .wr_clk (REF_CLK),
      .wr_en (FILL_EN),
      .wr_addr (FILL_ADDR),
      .wr_data (FILL_DATA),
      .rd_clk (INPUT_CLOCK_POS),
      .rd_addr (rd_pair),
      .rd_lo (rd_lo),
      .rd_hi (rd_hi)
   );

   // Positive-edge launch stage
   logic v_a_r;
   logic v_a_nxt;
   logic v_p_r;
   logic v_p_nxt;
   srp_pkg::srp_data_t q_p_r;
   srp_pkg::srp_data_t q_p_nxt;
   srp_pkg::srp_data_t hi_r;
   srp_pkg::srp_data_t hi_nxt;
   logic tog_p_r;
   logic tog_p_nxt;

   always_comb
   begin
      v_a_nxt = pair_ok;
      v_p_nxt = v_a_r;
      q_p_nxt = rd_lo;
      hi_nxt = rd_hi;
      tog_p_nxt = !tog_p_r;
   end

   always_ff @(posedge INPUT_CLOCK_POS or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
      begin
         v_a_r <= `SRP_BIT_RST;
         v_p_r <= `SRP_BIT_RST;
         q_p_r <= '0;
         hi_r <= '0;
         tog_p_r <= `SRP_BIT_RST;
      end
      else
      begin
         v_a_r <= v_a_nxt;
         v_p_r <= v_p_nxt;
         q_p_r <= q_p_nxt;
         hi_r <= hi_nxt;
         tog_p_r <= tog_p_nxt;
      end
   end

   // Negative-clock launch stage, half a period behind
   logic v_n_r;
   logic v_n_nxt;
   srp_pkg::srp_data_t q_n_r;
   srp_pkg::srp_data_t q_n_nxt;
   logic tog_n_r;
   logic tog_n_nxt;

   always_comb
   begin
      v_n_nxt = v_p_r;
      q_n_nxt = hi_r;
      tog_n_nxt = tog_p_r;
   end

   always_ff @(posedge INPUT_CLOCK_NEG or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
      begin
         v_n_r <= `SRP_BIT_RST;
         q_n_r <= '0;
         tog_n_r <= `SRP_BIT_RST;
      end
      else
      begin
         v_n_r <= v_n_nxt;
         q_n_r <= q_n_nxt;
         tog_n_r <= tog_n_nxt;
      end
   end

   // Double-rate output select; toggles differ from one rise to the other.
   // Only a two-flop mux follows, so skew to the echo clocks stays small.
   logic phase;

   always_comb
   begin
      phase = tog_p_r ^ tog_n_r;
      READ_DATA_OUT = phase ? q_p_r : q_n_r;
      // Drivers follow valid, so deselect tristates with no other input
      READ_DATA_OE = phase ? v_p_r : v_n_r;
      READ_DATA_VALID = phase ? v_p_r : v_n_r;
      ECHO_CLOCK = phase;
      ECHO_CLOCK_N = !phase;
   end

   // Checks
   AST_START_SECOND:
      assert property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         start |=> burst_r == srp_pkg::SRP_SECOND)
      else $error("Select low did not open a burst");

   AST_BUSY_IGNORED:
      assert property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         burst_r == srp_pkg::SRP_SECOND |=> burst_r == srp_pkg::SRP_OPEN)
      else $error("Burst ran longer than two periods");

   AST_VALID_SPAN:
      assert property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         start |=> ##1 v_p_r ##1 v_p_r)
      else $error("Valid did not cover the burst");

   AST_COMPLETE:
      assert property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         (burst_r == srp_pkg::SRP_SECOND && READ_PORT_SELECT_N) |=> ##1 v_p_r)
      else $error("Deselect cut a burst short");

   AST_IDLE_OFF:
      assert property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         (!pair_ok ##1 !pair_ok) |=> ##1 !v_p_r)
      else $error("Valid high with no burst");

   AST_ADDR_HELD:
      assert property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         !start |=> $stable(addr_r))
      else $error("Address taken while deselected");

   AST_BACK_TO_BACK:
      assert property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         (start ##2 start) |-> v_p_r[*4])
      else $error("Gap between back-to-back bursts");

   AST_NEG_FOLLOW:
      assert property (@(posedge INPUT_CLOCK_NEG) disable iff (!link_rst_n_r)
         v_n_r == $past(v_p_r) && q_n_r == $past(hi_r))
      else $error("Negative beat not from positive stage");

   COV_SINGLE:
      cover property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         start ##1 READ_PORT_SELECT_N ##1 READ_PORT_SELECT_N);

   COV_BACK:
      cover property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         start ##2 start ##2 start);

   COV_BUSY_SEL:
      cover property (@(posedge INPUT_CLOCK_POS) disable iff (!link_rst_n_r)
         burst_r == srp_pkg::SRP_SECOND && !READ_PORT_SELECT_N);

endmodule

`default_nettype wire

// ---- shared/srp_consts.svh ----
`ifndef SRP_CONSTS_SVH
`define SRP_CONSTS_SVH

// Beat width, narrow configuration
`define SRP_DATA_W 18
// Beat width, wide configuration
`define SRP_DATA_W_WIDE 36
// Burst address bits held by the model array
`define SRP_ADDR_W 6
// Beats in one read burst
`define SRP_BURST_LEN 4
// Beats launched per input clock period
`define SRP_BEATS_PER_CYC 2
// Reset values
`define SRP_ADDR_RST 6'h00
`define SRP_BIT_RST 1'h0

`endif

// ---- shared/srp_pkg.sv ----
`default_nettype none

`include "srp_consts.svh"

package srp_pkg;

   typedef logic [`SRP_DATA_W-1:0] srp_data_t;
   typedef logic [`SRP_ADDR_W-1:0] srp_addr_t;
   // Pair index within the array: burst address plus upper/lower pair
   typedef logic [`SRP_ADDR_W:0] srp_pair_t;
   // Beat index within the array: burst address plus burst position
   typedef logic [`SRP_ADDR_W+1:0] srp_beat_t;

   typedef enum logic [0:0] {
      SRP_OPEN = 1'b0,
      SRP_SECOND = 1'b1
   } srp_burst_e;

endpackage

`default_nettype wire

// ---- verification/srp_ctl_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module srp_ctl_model
(
   // Input clock pair
   output logic k,
   output logic k_n,
   // Read request
   output logic sel_n,
   output srp_pkg::srp_addr_t addr
);
   // Input clocks run free; phase offset keeps them unrelated to REF_CLK.
   // Both start low so no clock rise lands before reset is applied.
   initial
   begin
      k = 1'b0;
      k_n = 1'b0;
      sel_n = 1'b1;
      addr = 6'h2a;
      #27;
      k_n = 1'b1;
      forever
      begin
         #40;
         k = ~k;
         k_n = ~k_n;
      end
   end

   // Select low for n rises; n of 2 asks for a refused second start
   task rd(input srp_pkg::srp_addr_t a, input int n);
      repeat (n)
      begin
         @(posedge k);
         @(negedge k);
         sel_n = 1'b0;
         addr = a;
      end
      @(posedge k);
      @(negedge k);
      sel_n = 1'b1;
      // Stale address must not leak into a burst
      addr = ~a;
   endtask
endmodule

`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

`define CHK(x, y) \
   begin \
      comparisons++; \
      if ((x) !== (y)) \
      begin \
         errors++; \
         $display("[FAIL] %0t got %h want %h", $time, x, y); \
      end \
   end

module tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic fill_en = 1'b0;
   srp_pkg::srp_beat_t fill_addr = 8'h00;
   srp_pkg::srp_data_t fill_data = 18'h00000;
   logic k, k_n, sel_n, oe, vld, eck, eck_n;
   srp_pkg::srp_addr_t addr;
   srp_pkg::srp_data_t q;
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;

   initial forever #25 clk = ~clk;

   // Whole run is about 560 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         errors++;
         end_sim;
      end
   end

   srp_read_port u_dut
   (
      .REF_CLK(clk),
      .NRST(nrst),
      .FILL_EN(fill_en),
      .FILL_ADDR(fill_addr),
      .FILL_DATA(fill_data),
      .INPUT_CLOCK_POS(k),
      .INPUT_CLOCK_NEG(k_n),
      .READ_PORT_SELECT_N(sel_n),
      .ADDRESS(addr),
      .READ_DATA_OUT(q),
      .READ_DATA_OE(oe),
      .READ_DATA_VALID(vld),
      .ECHO_CLOCK(eck),
      .ECHO_CLOCK_N(eck_n)
   );

   srp_ctl_model m
   (
      .k(k),
      .k_n(k_n),
      .sel_n(sel_n),
      .addr(addr)
   );

   function srp_pkg::srp_data_t wd(input srp_pkg::srp_addr_t a,
                                   input logic [1:0] p);
      return {a, p, a, p, 2'h2};
   endfunction

   task end_sim;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task idle;
      `CHK(vld, 1'b0)
      `CHK(oe, 1'b0)
   endtask

   // Entered right at a K rise carrying beat 0; leaves two rises later
   task beats(input srp_pkg::srp_addr_t a);
      for (int p = 0; p < 4; p++)
      begin
         #20;
         `CHK(q, wd(a, p[1:0]))
         `CHK(vld, 1'b1)
         `CHK(oe, 1'b1)
         `CHK(eck, p[0] == 0)
         `CHK(eck_n, p[0] != 0)
         if (p[0])
            @(posedge k);
         else
            @(negedge k);
      end
   endtask

   task s_reset;
      `CHK(vld, 1'b0)
      `CHK(oe, 1'b0)
      `CHK(eck_n, 1'b1)
   endtask

   task s_fill;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 256; i++)
      begin
         @(negedge clk);
         fill_en = 1'b1;
         fill_addr = i[7:0];
         fill_data = wd(i[7:2], i[1:0]);
         @(negedge clk);
         fill_en = 1'b0;
      end
   endtask

   // Select is taken at the second rise; first beat leaves one period later
   task s_single;
      fork
         m.rd(6'h15, 1);
         begin
            repeat (3) @(posedge k);
            beats(6'h15);
            #20;
            idle;
         end
      join
   endtask

   task s_b2b;
      fork
         begin
            m.rd(6'h3f, 1);
            m.rd(6'h00, 1);
         end
         begin
            repeat (3) @(posedge k);
            beats(6'h3f);
            beats(6'h00);
            #20;
            idle;
         end
      join
   endtask

   task s_refused;
      fork
         m.rd(6'h2b, 2);
         begin
            repeat (3) @(posedge k);
            beats(6'h2b);
            #20;
            idle;
         end
      join
   endtask

   initial
   begin
      repeat (4) @(negedge clk);
      s_reset;
      nrst = 1'b1;
      s_fill;
      repeat (6) @(posedge k);
      #20;
      idle;
      s_single;
      s_b2b;
      s_refused;
      end_sim;
   end
endmodule

`default_nettype wire
